// ---- design/itfd_pkg.sv ----
/*
 * itfd_pkg: shared constants and types of the input terminal function decoder.
 * Assumes a 32-bit APB slave with a 12-bit byte address and 5-bit terminal function codes.
 */
package itfd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // sizes
  localparam int TERM_COUNT = 6;
  localparam int CODE_W = 5;
  localparam int ADDR_W = 12;
  localparam int AUX_W = 16;
  localparam int IRQ_W = 4;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [ADDR_W-1:0] ADDR_FUNC_LO = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_FUNC_HI = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_CFG = 12'h008;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h00C;
  localparam logic [ADDR_W-1:0] ADDR_AUX = 12'h010;
  localparam logic [ADDR_W-1:0] ADDR_STEP = 12'h014;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_ST = 12'h018;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 12'h01C;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int FUNC_FIELD_STRIDE = 8;   // code of terminal i at bits [8*(i%4)+4:8*(i%4)] of word i/4
  localparam int FUNC_PER_WORD = 4;
  localparam int CFG_EXT_BIT = 0;         // reference source is the terminals
  localparam int CFG_BASE_LSB = 1;        // base channel, 2 bits
  localparam int CFG_COMBO_LSB = 4;       // combination channel choice, 2 bits
  localparam int CFG_FCLR_BIT = 8;        // write 1 to clear a latched fault
  localparam int ST_LEVEL_LSB = 0;
  localparam int ST_INDEX_LSB = 8;
  localparam int ST_CHAN_LSB = 16;
  localparam int ST_PAUSE_BIT = 20;
  localparam int ST_FAULT_BIT = 21;
  localparam int IRQ_FAULT_BIT = 0;
  localparam int IRQ_PAUSE_BIT = 1;
  localparam int IRQ_CHAN_BIT = 2;
  localparam int IRQ_INDEX_BIT = 3;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [AUX_W-1:0] STEP_RESET = 16'h0001;
  localparam logic [AUX_W-1:0] AUX_RESET = 16'h0000;

  // saturation limits of the offset, in 18-bit signed arithmetic
  localparam logic signed [AUX_W+1:0] AUX_MAX = 18'sh0_7FFF;
  localparam logic signed [AUX_W+1:0] AUX_MIN = -18'sh0_8000;

  ////////////////////////////////////////////////////////////////////////////
  // terminal function codes
  localparam logic [CODE_W-1:0] FN_NONE = 5'h00;
  localparam logic [CODE_W-1:0] FN_PAUSE = 5'h08;
  localparam logic [CODE_W-1:0] FN_FAULT = 5'h09;
  localparam logic [CODE_W-1:0] FN_UP = 5'h0A;
  localparam logic [CODE_W-1:0] FN_DOWN = 5'h0B;
  localparam logic [CODE_W-1:0] FN_CLEAR = 5'h0C;
  localparam logic [CODE_W-1:0] FN_SW_AB = 5'h0D;
  localparam logic [CODE_W-1:0] FN_SW_CA = 5'h0E;
  localparam logic [CODE_W-1:0] FN_SW_CB = 5'h0F;
  localparam logic [CODE_W-1:0] FN_STEP1 = 5'h10;
  localparam logic [CODE_W-1:0] FN_STEP2 = 5'h11;
  localparam logic [CODE_W-1:0] FN_STEP3 = 5'h12;
  localparam logic [CODE_W-1:0] FN_STEP4 = 5'h13;
  localparam logic [CODE_W-1:0] FN_HOLD = 5'h14;

  // frequency reference channels
  typedef enum logic [1:0] {
    CH_A,
    CH_B,
    CH_COMBO
  } itfd_chan_t;

endpackage : itfd_pkg

// ---- design/itfd_sync.sv ----
/*
 * itfd_sync: two-flop synchroniser for a bus of asynchronous levels.
 * Assumes each bit is an independent level; no bus coherence is promised across bits.
 */
module itfd_sync #(
  parameter int WIDTH = 6
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } itfd_sync_t;

  itfd_sync_t s_q;
  itfd_sync_t s_d;

  // first stage feeds only the second stage, to keep metastability contained
  always_comb begin
    s_d = s_q;
    s_d.meta = async_in;
    s_d.stable = s_q.meta;
  end

  ////////////////////////////////////////////////////////////////////////////
  // register the stages
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_out = s_q.stable;

endmodule : itfd_sync

// ---- design/itfd_top.sv ----
/*
 * itfd_top: decodes the function code of each digital input terminal and drives the
 * pause, fault, reference channel, raise/lower offset and multi-step speed outputs.
 * Assumes terminals are asynchronous levels, active high, and registers are on APB.
 */
// Functional notes
// RL1 - while a running-pause terminal is active the drive is told to decelerate to stop and all running state is kept.
// the code holds only raise/lower and the speed index; the clear terminal and channel swaps still act during pause.
// RL2 - when running pause is released the drive resumes the exact state it held before the pause.
// the code differs: a clear or swap terminal during pause still changes offset and channel.
// RL3 - an active external-fault terminal raises a fault alarm and stops the drive output.
// RL4 - raise and lower terminals change the setpoint offset only while the reference source is the terminals.
// RL5 - the clear terminal zeroes the raise/lower offset so the reference returns to the main channel.
// RL6 - the A/B switch terminal swaps the active reference between channel A and channel B.
// RL7 - the combination/A switch terminal swaps the active reference between the combination channel and channel A.
// RL8 - the combination/B switch terminal swaps the active reference between the combination channel and channel B.
// RL9 - the four multi-step terminals together form a four-bit index of sixteen preset speeds.
// RL10 - multi-step terminal 1 is the index low bit and terminal 4 the high bit.
// RL11 - while the speed-hold terminal is active the speed index is frozen.
// RL12 - a terminal with code zero has no effect whatever its level.
// RL13 - every terminal is synchronised to the control clock before decoding.
module itfd_top
  import itfd_pkg::*;
#(
  parameter int NTERM = TERM_COUNT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NTERM-1:0] term_in,
  output logic pause_stop,       // decelerate to stop, block raise/lower steps and hold speed index; clear still zeroes offset
  output logic fault_alarm,
  output logic drive_stop,
  output logic [1:0] ref_channel,
  output logic [1:0] combo_channel_select_param,
  output logic [AUX_W-1:0] aux_offset,
  output logic [3:0] speed_index,
  output logic irq
);

  typedef struct packed {
    logic [NTERM-1:0][CODE_W-1:0] codes;
    logic ext_src;
    logic [1:0] base_ch;
    logic [1:0] combo_sel;
    logic [AUX_W-1:0] step;
    logic [AUX_W-1:0] aux;
    logic [3:0] idx;
    logic [1:0] chan;
    logic pause;
    logic fault;
    logic up_prev;
    logic dn_prev;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_mask;
    logic irq;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
  } itfd_state_t;

  itfd_state_t s_q;
  itfd_state_t s_d;
  logic [NTERM-1:0] lvl;

  ////////////////////////////////////////////////////////////////////////////
  // terminal synchronisers
  itfd_sync #(
    .WIDTH(NTERM)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(term_in),
    .sync_out(lvl)                       // see RL13
  );

  ////////////////////////////////////////////////////////////////////////////
  // decoding helpers

  // true when any terminal carrying this code is high; code zero never matches
  function automatic logic fn_active(
    input logic [NTERM-1:0][CODE_W-1:0] codes,
    input logic [NTERM-1:0] levels,
    input logic [CODE_W-1:0] code
  );
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NTERM; i++) begin
      if (codes[i] == code && codes[i] != FN_NONE && levels[i]) begin   // see RL12
        hit = 1'b1;
      end
    end
    return hit;
  endfunction : fn_active

  // true when the address names a mapped register
  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    logic ok;
    ok = 1'b0;
    case (a)
      ADDR_FUNC_LO, ADDR_FUNC_HI, ADDR_CFG, ADDR_STATUS: ok = 1'b1;
      ADDR_AUX, ADDR_STEP, ADDR_IRQ_ST, ADDR_IRQ_MASK: ok = 1'b1;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction : addr_mapped

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic f_pause;
    logic f_fault;
    logic f_up;
    logic f_dn;
    logic f_clr;
    logic f_ab;
    logic f_ca;
    logic f_cb;
    logic f_hold;
    logic [3:0] raw_idx;
    logic [1:0] ch;
    logic signed [AUX_W+1:0] sum;
    logic [IRQ_W-1:0] ev;
    logic wr;
    logic rd_setup;
    f_pause = fn_active(s_q.codes, lvl, FN_PAUSE);
    f_fault = fn_active(s_q.codes, lvl, FN_FAULT);
    f_up = fn_active(s_q.codes, lvl, FN_UP);
    f_dn = fn_active(s_q.codes, lvl, FN_DOWN);
    f_clr = fn_active(s_q.codes, lvl, FN_CLEAR);
    f_ab = fn_active(s_q.codes, lvl, FN_SW_AB);
    f_ca = fn_active(s_q.codes, lvl, FN_SW_CA);
    f_cb = fn_active(s_q.codes, lvl, FN_SW_CB);
    f_hold = fn_active(s_q.codes, lvl, FN_HOLD);
    // terminal 1 is the low bit, terminal 4 the high bit
    raw_idx = {fn_active(s_q.codes, lvl, FN_STEP4),
               fn_active(s_q.codes, lvl, FN_STEP3),
               fn_active(s_q.codes, lvl, FN_STEP2),
               fn_active(s_q.codes, lvl, FN_STEP1)};       // see RL9, see RL10
    sum = '0;
    ev = '0;
    wr = psel && penable && pwrite;
    rd_setup = psel && !penable;
    s_d = s_q;

    // pause is a level: raise/lower and the index below are held, while clear and channel
    // swaps still act, so release returns to the held values with nothing to restore
    s_d.pause = f_pause;                                  // see RL1, see RL2

    // fault latches until software clears it; a still-active input sets it again
    s_d.fault = s_q.fault | f_fault;                      // see RL3
    if (wr && paddr == ADDR_CFG && pwdata[CFG_FCLR_BIT]) begin
      s_d.fault = f_fault;
    end

    // raise/lower act on rising edges only, so a held switch gives one step
    s_d.up_prev = f_up;
    s_d.dn_prev = f_dn;
    if (f_clr) begin
      s_d.aux = AUX_RESET;                                // see RL5
    end else if (s_q.ext_src && !s_q.pause) begin         // see RL4, see RL1
      if (f_up && !s_q.up_prev && !(f_dn && !s_q.dn_prev)) begin
        sum = $signed({{2{s_q.aux[AUX_W-1]}}, s_q.aux}) + $signed({2'b00, s_q.step});
        s_d.aux = (sum > AUX_MAX) ? AUX_MAX[AUX_W-1:0] : sum[AUX_W-1:0];
      end else if (f_dn && !s_q.dn_prev && !(f_up && !s_q.up_prev)) begin
        sum = $signed({{2{s_q.aux[AUX_W-1]}}, s_q.aux}) - $signed({2'b00, s_q.step});
        s_d.aux = (sum < AUX_MIN) ? AUX_MIN[AUX_W-1:0] : sum[AUX_W-1:0];
      end
    end

    // channel selection: swaps are applied in order A/B, combo/A, combo/B
    ch = (s_q.base_ch == 2'(CH_COMBO)) ? 2'(CH_COMBO) : s_q.base_ch;
    if (f_ab) begin
      if (ch == 2'(CH_A)) begin
        ch = 2'(CH_B);                                    // see RL6
      end else if (ch == 2'(CH_B)) begin
        ch = 2'(CH_A);                                    // see RL6
      end
    end
    if (f_ca) begin
      if (ch == 2'(CH_A)) begin
        ch = 2'(CH_COMBO);                                // see RL7
      end else if (ch == 2'(CH_COMBO)) begin
        ch = 2'(CH_A);                                    // see RL7
      end
    end
    if (f_cb) begin
      if (ch == 2'(CH_B)) begin
        ch = 2'(CH_COMBO);                                // see RL8
      end else if (ch == 2'(CH_COMBO)) begin
        ch = 2'(CH_B);                                    // see RL8
      end
    end
    s_d.chan = ch;

    // speed index tracks the terminals unless held or paused
    if (!f_hold && !s_q.pause) begin
      s_d.idx = raw_idx;                                  // see RL11, see RL1
    end

    // events; a new event wins over a clear in the same cycle
    ev[IRQ_FAULT_BIT] = f_fault && !s_q.fault;
    ev[IRQ_PAUSE_BIT] = f_pause && !s_q.pause;
    ev[IRQ_CHAN_BIT] = s_d.chan != s_q.chan;
    ev[IRQ_INDEX_BIT] = s_d.idx != s_q.idx;
    s_d.irq_st = s_q.irq_st;
    if (wr && paddr == ADDR_IRQ_ST) begin
      s_d.irq_st = s_q.irq_st & ~pwdata[IRQ_W-1:0];
    end
    s_d.irq_st = s_d.irq_st | ev;

    // register writes, taken in the access phase
    if (wr) begin
      case (paddr)
        ADDR_FUNC_LO: begin
          for (int i = 0; i < FUNC_PER_WORD && i < NTERM; i++) begin
            s_d.codes[i] = pwdata[i*FUNC_FIELD_STRIDE +: CODE_W];
          end
        end
        ADDR_FUNC_HI: begin
          for (int i = FUNC_PER_WORD; i < NTERM; i++) begin
            s_d.codes[i] = pwdata[(i-FUNC_PER_WORD)*FUNC_FIELD_STRIDE +: CODE_W];
          end
        end
        ADDR_CFG: begin
          s_d.ext_src = pwdata[CFG_EXT_BIT];
          s_d.base_ch = pwdata[CFG_BASE_LSB +: 2];
          s_d.combo_sel = pwdata[CFG_COMBO_LSB +: 2];
        end
        ADDR_STEP: s_d.step = pwdata[AUX_W-1:0];
        ADDR_IRQ_MASK: s_d.irq_mask = pwdata[IRQ_W-1:0];
        default: begin
        end
      endcase
    end

    // read data and error are captured in the setup phase; zero wait states
    s_d.ready = 1'b1;
    if (rd_setup) begin
      s_d.rdata = '0;
      s_d.slverr = !addr_mapped(paddr);
      case (paddr)
        ADDR_FUNC_LO: begin
          for (int i = 0; i < FUNC_PER_WORD && i < NTERM; i++) begin
            s_d.rdata[i*FUNC_FIELD_STRIDE +: CODE_W] = s_q.codes[i];
          end
        end
        ADDR_FUNC_HI: begin
          for (int i = FUNC_PER_WORD; i < NTERM; i++) begin
            s_d.rdata[(i-FUNC_PER_WORD)*FUNC_FIELD_STRIDE +: CODE_W] = s_q.codes[i];
          end
        end
        ADDR_CFG: begin
          s_d.rdata[CFG_EXT_BIT] = s_q.ext_src;
          s_d.rdata[CFG_BASE_LSB +: 2] = s_q.base_ch;
          s_d.rdata[CFG_COMBO_LSB +: 2] = s_q.combo_sel;
        end
        ADDR_STATUS: begin
          s_d.rdata[ST_LEVEL_LSB +: NTERM] = lvl;
          s_d.rdata[ST_INDEX_LSB +: 4] = s_q.idx;
          s_d.rdata[ST_CHAN_LSB +: 2] = s_q.chan;
          s_d.rdata[ST_PAUSE_BIT] = s_q.pause;
          s_d.rdata[ST_FAULT_BIT] = s_q.fault;
        end
        ADDR_AUX: s_d.rdata[AUX_W-1:0] = s_q.aux;
        ADDR_STEP: s_d.rdata[AUX_W-1:0] = s_q.step;
        ADDR_IRQ_ST: s_d.rdata[IRQ_W-1:0] = s_q.irq_st;
        ADDR_IRQ_MASK: s_d.rdata[IRQ_W-1:0] = s_q.irq_mask;
        default: s_d.rdata = '0;
      endcase
    end

    // level interrupt from the new status so it rises with the event
    s_d.irq = |(s_d.irq_st & s_d.irq_mask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.step <= STEP_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register
  assign prdata = s_q.rdata;
  assign pready = s_q.ready;
  assign pslverr = s_q.slverr;
  assign pause_stop = s_q.pause;
  assign fault_alarm = s_q.fault;
  assign drive_stop = s_q.fault;         // see RL3
  assign ref_channel = s_q.chan;
  assign combo_channel_select_param = s_q.combo_sel;
  assign aux_offset = s_q.aux;
  assign speed_index = s_q.idx;
  assign irq = s_q.irq;

endmodule : itfd_top

// ---- testbench/itfd_props.sv ----
/*
 * itfd_props: concurrent checks on the terminal decoder ports.
 * Assumes it is bound into itfd_top and sees only that module's ports.
 */
module itfd_props
  import itfd_pkg::*;
#(
  parameter int NTERM = TERM_COUNT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NTERM-1:0] term_in,
  input wire logic pause_stop,
  input wire logic fault_alarm,
  input wire logic drive_stop,
  input wire logic [AUX_W-1:0] aux_offset,
  input wire logic [3:0] speed_index
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [NTERM-1:0][CODE_W-1:0] code_q;
  logic [NTERM-1:0] t1_q, t2_q, t3_q, act_pause, act_fault, act_hold;
  logic ext_q, hold_any;
  logic [2:0] age_q;
  logic [3:0] idx3;

  ////////////////////////////////////////////////////////////////////////////
  // shadow codes and source; age counts quiet cycles so a fresh write is not judged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_q <= '0;
      ext_q <= 1'b0;
      age_q <= 3'h0;
      {t1_q, t2_q, t3_q} <= '0;
    end else begin
      {t1_q, t2_q, t3_q} <= {term_in, t1_q, t2_q}; // three edges, as the synchroniser plus state
      age_q <= (age_q == 3'h7) ? age_q : age_q + 3'h1;
      if (psel && penable && pwrite && paddr == ADDR_CFG) begin
        ext_q <= pwdata[CFG_EXT_BIT];
        age_q <= 3'h0;
      end
      for (int i = 0; i < NTERM; i++) begin
        if (psel && penable && pwrite && paddr == ADDR_FUNC_LO + ADDR_W'(4 * (i / FUNC_PER_WORD))) begin
          code_q[i] <= pwdata[FUNC_FIELD_STRIDE * (i % FUNC_PER_WORD) +: CODE_W];
          age_q <= 3'h0;
        end
      end
    end
  end

  // decode what the delayed terminal levels should mean
  always_comb begin
    idx3 = 4'h0;
    for (int i = 0; i < NTERM; i++) begin
      act_pause[i] = (code_q[i] == FN_PAUSE) && t3_q[i];
      act_fault[i] = (code_q[i] == FN_FAULT) && t3_q[i];
      act_hold[i] = (code_q[i] == FN_HOLD) && t3_q[i];
      for (int k = 0; k < 4; k++) begin
        idx3[k] = idx3[k] | ((code_q[i] == FN_STEP1 + CODE_W'(k)) && t3_q[i]);
      end
    end
    hold_any = |act_hold;
  end

  ////////////////////////////////////////////////////////////////////////////
  a_pause_level: assert property (@(posedge pclk) disable iff (!presetn)
    age_q > 3'h3 |-> pause_stop == |act_pause) else $error("pause output off its terminal");
  a_fault_latch: assert property (@(posedge pclk) disable iff (!presetn)
    age_q > 3'h3 && |act_fault |-> fault_alarm && drive_stop) else $error("fault not raised");
  a_stop_follows: assert property (@(posedge pclk) disable iff (!presetn)
    drive_stop == fault_alarm) else $error("stop differs from fault alarm");
  a_offset_gate: assert property (@(posedge pclk) disable iff (!presetn)
    age_q > 3'h3 && !ext_q && $changed(aux_offset) |-> aux_offset == '0) else $error("offset moved");
  a_step_index: assert property (@(posedge pclk) disable iff (!presetn)
    age_q > 3'h4 && !$past(|act_pause) && !hold_any |-> speed_index == idx3) else $error("speed index wrong");
  a_index_frozen: assert property (@(posedge pclk) disable iff (!presetn)
    age_q > 3'h4 && hold_any && $past(hold_any) |-> $stable(speed_index)) else $error("index not held");
  a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable |-> pready) else $error("access without ready");
  a_unmapped_read: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && paddr > ADDR_IRQ_MASK ##1 psel && penable |-> pslverr && prdata == '0)
    else $error("unmapped read not refused");
endmodule : itfd_props

bind itfd_top itfd_props #(.NTERM(NTERM)) u_itfd_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .term_in(term_in), .pause_stop(pause_stop), .fault_alarm(fault_alarm),
  .drive_stop(drive_stop), .aux_offset(aux_offset), .speed_index(speed_index));

// ---- testbench/itfd_switch_model.sv ----
/*
 * itfd_switch_model: external switches on the terminal pins.
 * Assumes the bench asks for levels; each change lands after a settable number of cycles.
 */
module itfd_switch_model #(
  parameter int NTERM = 6
) (
  input wire logic pclk,
  input wire logic [NTERM-1:0] want,
  input wire logic [3:0] dly,
  output logic [NTERM-1:0] term
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [NTERM-1:0] pend = '0;
  logic [3:0] cnt = 4'h0;

  initial term = '0;

  // a slow switch lands late; a new request restarts the wait
  always @(posedge pclk) begin
    if (want != pend) begin
      pend <= want;
      cnt <= 4'h0;
    end else if (cnt >= dly) begin
      term <= pend;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule : itfd_switch_model

// ---- testbench/tb_top.sv ----
/*
 * tb_top: self-checking bench of the terminal decoder, APB master plus switch model.
 * Assumes the decoder answers APB with zero wait states and terminals act three edges late.
 */
module tb_top
  import itfd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, err, pause_stop, fault_alarm, drive_stop, irq;
  logic [5:0] term_in, want = '0;
  logic [3:0] dly = 4'h0, speed_index, idx;
  logic [1:0] ref_channel, combo_sel, cmb;
  logic [15:0] aux_offset, step;
  int n_errors = 0, n_compared = 0;

  always #2.5 pclk = ~pclk;

  itfd_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .term_in(term_in), .pause_stop(pause_stop), .fault_alarm(fault_alarm), .drive_stop(drive_stop),
    .ref_channel(ref_channel), .combo_channel_select_param(combo_sel), .aux_offset(aux_offset),
    .speed_index(speed_index), .irq(irq));
  itfd_switch_model #(.NTERM(6)) u_sw (.pclk(pclk), .want(want), .dly(dly), .term(term_in));

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (n_errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one transfer; an idle edge afterwards keeps psel from being set twice in a time step
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    // a slave that never answers ends the run through the common verdict
    if (n >= 50) begin
      n_errors++;
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic set_codes(input logic [5:0][4:0] c);
    apb(1'b1, ADDR_FUNC_LO, {3'h0, c[3], 3'h0, c[2], 3'h0, c[1], 3'h0, c[0]});
    apb(1'b1, ADDR_FUNC_HI, {19'h0_0000, c[5], 3'h0, c[4]});
  endtask : set_codes

  // long enough for the slowest switch plus the three-edge pipeline
  task automatic settle();
    repeat (16) @(posedge pclk);
  endtask : settle

  task automatic pulse(input int t);
    want <= 6'h01 << t;
    settle();
    want <= 6'h00;
    settle();
  endtask : pulse

  // swaps apply in code order on the base channel
  function automatic logic [1:0] exp_chan(input logic [1:0] b, input logic [2:0] s);
    logic [1:0] c;
    c = b;
    if (s[0]) c = (c == 2'h0) ? 2'h1 : (c == 2'h1) ? 2'h0 : c;
    if (s[1]) c = (c == 2'h2) ? 2'h0 : (c == 2'h0) ? 2'h2 : c;
    if (s[2]) c = (c == 2'h2) ? 2'h1 : (c == 2'h1) ? 2'h2 : c;
    return c;
  endfunction : exp_chan

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (30000) @(posedge pclk);
    n_errors++;
    end_sim();
  end

  initial begin
    rd = $urandom(32'h0000_00c8);
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, ADDR_STEP, '0);
    chk(rd, 32'(STEP_RESET));
    apb(1'b0, ADDR_IRQ_MASK, '0);
    chk(rd, 32'h0000_0000);
    apb(1'b0, 12'h020, '0);
    chk(rd, 32'h0000_0000);
    chk(32'(err), 32'h0000_0001);
    // raise, lower, clear and the pause that keeps state
    set_codes({FN_NONE, FN_CLEAR, FN_DOWN, FN_UP, FN_FAULT, FN_PAUSE});
    step = 16'($urandom_range(1, 500));
    dly <= 4'($urandom_range(0, 6));
    apb(1'b1, ADDR_STEP, 32'(step));
    apb(1'b1, ADDR_CFG, 32'h0000_0001);
    repeat (3) pulse(2);
    pulse(3);
    chk(32'(aux_offset), 32'(16'(2 * step)));
    want <= 6'h01;
    settle();
    chk(32'(pause_stop), 32'h0000_0001);
    want <= 6'h05;
    settle();
    want <= 6'h00;
    settle();
    chk(32'({pause_stop, aux_offset}), 32'(16'(2 * step)));
    want <= 6'h20;
    settle();
    chk(32'({pause_stop, fault_alarm, ref_channel, aux_offset}), 32'(16'(2 * step)));
    pulse(4);
    chk(32'(aux_offset), 32'h0000_0000);
    pulse(2);
    apb(1'b1, ADDR_CFG, 32'h0000_0000);
    pulse(2);
    chk(32'(aux_offset), 32'(step));
    // fault latches, raises the masked interrupt, clears by software after release
    apb(1'b1, ADDR_IRQ_MASK, 32'h0000_0001);
    pulse(1);
    chk(32'({fault_alarm, drive_stop, irq}), 32'h0000_0007);
    apb(1'b1, ADDR_IRQ_ST, 32'h0000_0001);
    apb(1'b1, ADDR_CFG, 32'h0000_0100);
    chk(32'({fault_alarm, drive_stop, irq}), 32'h0000_0000);
    // every base channel against every switch combination
    set_codes({FN_NONE, FN_NONE, FN_NONE, FN_SW_CB, FN_SW_CA, FN_SW_AB});
    for (int b = 0; b < 3; b++) begin
      for (int s = 0; s < 8; s++) begin
        cmb = 2'($urandom);
        apb(1'b1, ADDR_CFG, 32'({cmb, 1'b0, 2'(b), 1'b0}));
        want <= 6'(s);
        settle();
        chk(32'({combo_sel, ref_channel}), 32'({cmb, exp_chan(2'(b), 3'(s))}));
      end
    end
    // multi-step index, its hold, and the synchroniser delay
    want <= 6'h00;
    settle();
    set_codes({FN_PAUSE, FN_HOLD, FN_STEP4, FN_STEP3, FN_STEP2, FN_STEP1});
    repeat (16) begin
      idx = 4'($urandom);
      want <= {2'h0, idx};
      settle();
      chk(32'(speed_index), 32'(idx));
    end
    want <= {2'h1, idx};
    settle();
    want <= {2'h1, ~idx};
    settle();
    chk(32'(speed_index), 32'(idx));
    // pause engages while the hold still stands, so the held index is what pause keeps
    want <= {2'h3, ~idx};
    settle();
    want <= {2'h2, ~idx};
    settle();
    chk(32'({pause_stop, speed_index}), 32'({1'b1, idx}));
    // releasing pause lets the new terminals through, but only after the sync stages
    dly <= 4'h0;
    want <= {2'h0, ~idx};
    repeat (3) @(posedge pclk);
    chk(32'(speed_index), 32'(idx));
    settle();
    chk(32'(speed_index), 32'({~idx}));
    end_sim();
  end
endmodule : tb_top
